// [verilog/qsb_sram_if.sv]
// The two clock phases are carried as two word lanes per i_ref_clk cycle:
// the _k signals belong to the positive rise, the _kb signals to the
// complementary rise half a cycle later.
`timescale 1ns/10ps
module qsb_sram_if
  import qsb_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // port selects and shared address
  input wire logic i_read_port_select_n,
  input wire logic i_write_port_select_n,
  input wire logic [QSB_AW-1:0] i_addr,
  // write data, positive and complementary phase
  input wire logic [QSB_WORD_W-1:0] i_wdata_k,
  input wire logic [QSB_WORD_W-1:0] i_wdata_kb,
  input wire logic [QSB_LANES_PER_WORD-1:0] i_byte_write_select_k_n,
  input wire logic [QSB_LANES_PER_WORD-1:0] i_byte_write_select_kb_n,
  // latency strap pin
  input wire logic i_dll_disable_n,
  // read data, positive and complementary phase
  output logic [QSB_WORD_W-1:0] o_rdata_k,
  output logic [QSB_WORD_W-1:0] o_rdata_kb,
  output logic o_rdata_oe,
  // current latency mode
  output logic o_legacy_latency_mode
);

  // strap synchroniser and latency mode
  logic dll_s1_r;
  logic dll_s2_r;
  logic dll_s3_r;
  logic legacy_r;

  // arbitration
  qsb_last_t last_r;
  qsb_last_t last_nxt;
  logic rd_sel;
  logic wr_sel;
  logic rd_go;
  logic wr_go;

  // read pipeline
  logic [QSB_AW-1:0] rd_addr_r;
  logic rd_req_r;
  logic rd_req2_r;
  logic rd_launch;
  logic rd_second_r;
  logic [QSB_HALF_W-1:0] rd_hi_r;
  logic [QSB_BURST_W-1:0] rd_burst;
  logic fwd_hit;
  logic [QSB_LANES-1:0] fwd_lane;

  // write pipeline
  logic [QSB_AW-1:0] wr_addr_r;
  logic wr_ph1_r;
  logic wr_ph2_r;
  logic [QSB_HALF_W-1:0] wr_lo_r;
  logic [QSB_HALF_LANES-1:0] wr_lane_lo_r;
  logic [QSB_BURST_W-1:0] wr_burst;
  logic [QSB_LANES-1:0] wr_lane_all;

  qsb_mem_if mem ();

  // active-low byte selects of both phases to lane enables, k phase in the low lanes
  function automatic logic [QSB_HALF_LANES-1:0] lane_en_of(
    input logic [QSB_LANES_PER_WORD-1:0] sel_k_n,
    input logic [QSB_LANES_PER_WORD-1:0] sel_kb_n
  );
    return {~sel_kb_n, ~sel_k_n};
  endfunction

  // the strap comes from a pin: three stages, change taken when 2 and 3 agree
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dll_s1_r <= 1'h1;
      dll_s2_r <= 1'h1;
      dll_s3_r <= 1'h1;
    end else begin
      dll_s1_r <= i_dll_disable_n;
      dll_s2_r <= dll_s1_r;
      dll_s3_r <= dll_s2_r;
    end
  end

  // latency mode follows the settled strap, low means legacy mode
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      legacy_r <= QSB_RST_LEGACY;
    end else if (dll_s2_r == dll_s3_r) begin
      legacy_r <= ~dll_s3_r;
    end
  end

  // mode is visible to the outside
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_legacy_latency_mode <= QSB_RST_LEGACY;
    end else begin
      o_legacy_latency_mode <= legacy_r;
    end
  end

  // selects are active low and only looked at on the positive edge
  // positive edge sampling
  assign rd_sel = ~i_read_port_select_n;
  assign wr_sel = ~i_write_port_select_n;

  // a port never starts on two edges in a row; ties go by the previous start
  // ignore back-to-back read
  assign rd_go = rd_sel && (last_r != QSB_LAST_READ);
  // read beats write unless a read just started
  assign wr_go = wr_sel && (last_r != QSB_LAST_WRITE) && !rd_go;

  // record which port started on this edge
  always_comb begin
    last_nxt = QSB_LAST_IDLE;
    if (rd_go) begin
      last_nxt = QSB_LAST_READ;
    end else if (wr_go) begin
      last_nxt = QSB_LAST_WRITE;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_r <= QSB_LAST_IDLE;
    end else begin
      case (last_nxt)
        QSB_LAST_READ: last_r <= QSB_LAST_READ;
        QSB_LAST_WRITE: last_r <= QSB_LAST_WRITE;
        default: last_r <= QSB_LAST_IDLE;
      endcase
    end
  end

  // read address register, loaded only when a read starts
  // capture read address
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_addr_r <= '0;
    end else if (rd_go) begin
      rd_addr_r <= i_addr;
    end
  end

  // read request pipeline, one stage per cycle of latency
  // starts on positive edge
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_req_r <= 1'h0;
    end else begin
      rd_req_r <= rd_go;
    end
  end

  // second stage, the launch point in two-cycle mode
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_req2_r <= 1'h0;
    end else begin
      rd_req2_r <= rd_req_r;
    end
  end

  // pick the launch edge from the latency mode
  // two-cycle latency
  assign rd_launch = legacy_r ? rd_req_r : rd_req2_r;

  // a write in its second data cycle to the same address is still in flight
  // forward newest write data
  assign fwd_hit = wr_ph2_r && (wr_addr_r == rd_addr_r);
  assign fwd_lane = fwd_hit ? wr_lane_all : '0;

  // stored burst with the in-flight write laid over it
  assign rd_burst = qsb_merge_lanes(mem.rd_data, wr_burst, fwd_lane);

  // second half of the burst waits here for the next cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_hi_r <= '0;
    end else if (rd_launch) begin
      rd_hi_r <= rd_burst[QSB_BURST_W-1:QSB_HALF_W];
    end
  end

  // second-half marker
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_second_r <= 1'h0;
    end else begin
      rd_second_r <= rd_launch;
    end
  end

  // output registers: words 0,1 on launch, words 2,3 one cycle later
  // registered read data
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata_k <= QSB_RST_WORD;
    end else if (rd_launch) begin
      o_rdata_k <= rd_burst[QSB_WORD_W-1:0];
    end else if (rd_second_r) begin
      o_rdata_k <= rd_hi_r[QSB_WORD_W-1:0];
    end
  end

  // complementary-phase output register: word 1, then word 3
  // registered read data
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata_kb <= QSB_RST_WORD;
    end else if (rd_launch) begin
      o_rdata_kb <= rd_burst[QSB_HALF_W-1:QSB_WORD_W];
    end else if (rd_second_r) begin
      o_rdata_kb <= rd_hi_r[QSB_HALF_W-1:QSB_WORD_W];
    end
  end

  // drive only while burst words are out; floats at the edge after the last
  // float after pending reads
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata_oe <= 1'h0;
    end else begin
      o_rdata_oe <= rd_launch || rd_second_r;
    end
  end

  // write address register, loaded only when a write starts
  // write side address
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_addr_r <= '0;
    end else if (wr_go) begin
      wr_addr_r <= i_addr;
    end
  end

  // write phases: first data cycle, then second data cycle with commit
  // inputs ignored outside a burst
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ph1_r <= 1'h0;
    end else begin
      wr_ph1_r <= wr_go;
    end
  end

  // second data cycle, the commit point
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ph2_r <= 1'h0;
    end else begin
      wr_ph2_r <= wr_ph1_r;
    end
  end

  // words 0 and 1 with their byte selects on the first data cycle
  // capture both phases
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_lo_r <= '0;
    end else if (wr_ph1_r) begin
      wr_lo_r <= {i_wdata_kb, i_wdata_k};
    end
  end

  // byte selects of words 0 and 1, taken with their data
  // selects sampled per word
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_lane_lo_r <= '0;
    end else if (wr_ph1_r) begin
      wr_lane_lo_r <= lane_en_of(i_byte_write_select_k_n, i_byte_write_select_kb_n);
    end
  end

  // full burst: captured first half plus words 2 and 3 arriving now
  // 72-bit burst
  // select 0 low lane, 1 high
  assign wr_burst = {i_wdata_kb, i_wdata_k, wr_lo_r};
  assign wr_lane_all = {lane_en_of(i_byte_write_select_k_n, i_byte_write_select_kb_n),
    wr_lane_lo_r};

  // commit at the second data edge; an empty lane mask writes nothing
  // masked word untouched
  assign mem.wr_en = wr_ph2_r;
  assign mem.wr_addr = wr_addr_r;
  assign mem.wr_data = wr_burst;
  assign mem.wr_lane = wr_lane_all;
  assign mem.rd_addr = rd_addr_r;

  // storage array
  qsb_burst_array qsb_burst_array_inst (
    .i_ref_clk (i_ref_clk),
    .mem (mem.array)
  );

endmodule

// [verilog/qsb_pkg.sv]
package qsb_pkg;

  // array geometry: one address holds a burst of four words
  localparam int unsigned QSB_AW = 20;
  localparam int unsigned QSB_WORD_W = 18;
  localparam int unsigned QSB_WORDS = 4;
  localparam int unsigned QSB_LANE_W = 9;
  localparam int unsigned QSB_LANES_PER_WORD = 2;
  localparam int unsigned QSB_BURST_W = QSB_WORD_W * QSB_WORDS;
  localparam int unsigned QSB_LANES = QSB_LANES_PER_WORD * QSB_WORDS;
  localparam int unsigned QSB_DEPTH = 2 ** QSB_AW;
  localparam int unsigned QSB_HALF_W = 2 * QSB_WORD_W;
  localparam int unsigned QSB_HALF_LANES = 2 * QSB_LANES_PER_WORD;

  // reset values of the latency mode and the read data output words
  localparam logic QSB_RST_LEGACY = 1'h0;
  localparam logic [QSB_WORD_W-1:0] QSB_RST_WORD = 18'h00000;

  // which port started an access on the previous positive edge
  typedef enum logic [1:0] {
    QSB_LAST_IDLE,
    QSB_LAST_READ,
    QSB_LAST_WRITE
  } qsb_last_t;

  // lane i covers bits i*9 +: 9; a set lane bit takes the new data
  function automatic logic [QSB_BURST_W-1:0] qsb_merge_lanes(
    input logic [QSB_BURST_W-1:0] old_data,
    input logic [QSB_BURST_W-1:0] new_data,
    input logic [QSB_LANES-1:0] lane_en
  );
    logic [QSB_BURST_W-1:0] res;
    res = old_data;
    for (int i = 0; i < QSB_LANES; i++) begin
      if (lane_en[i]) begin
        res[i*QSB_LANE_W +: QSB_LANE_W] = new_data[i*QSB_LANE_W +: QSB_LANE_W];
      end
    end
    return res;
  endfunction

endpackage

// [verilog/qsb_mem_if.sv]
`timescale 1ns/10ps
interface qsb_mem_if;
  import qsb_pkg::*;

  // commit of one full burst
  logic wr_en;
  logic [QSB_AW-1:0] wr_addr;
  logic [QSB_BURST_W-1:0] wr_data;
  logic [QSB_LANES-1:0] wr_lane;
  // burst lookup
  logic [QSB_AW-1:0] rd_addr;
  logic [QSB_BURST_W-1:0] rd_data;

  modport ctrl (
    output wr_en, wr_addr, wr_data, wr_lane, rd_addr,
    input rd_data
  );
  modport array (
    input wr_en, wr_addr, wr_data, wr_lane, rd_addr,
    output rd_data
  );
endinterface

// [verilog/qsb_burst_array.sv]
`timescale 1ns/10ps
module qsb_burst_array
  import qsb_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // port to the sequencer
  qsb_mem_if.array mem
);

  // storage, one 72-bit burst per address; data holds no reset
  logic [QSB_BURST_W-1:0] store_r [QSB_DEPTH];

  // byte-lane commit, unselected lanes keep their contents
  always_ff @(posedge i_ref_clk) begin
    if (mem.wr_en) begin
      store_r[mem.wr_addr] <= qsb_merge_lanes(store_r[mem.wr_addr], mem.wr_data, mem.wr_lane);
    end
  end

  // lookup, the sequencer adds forwarding on top
  assign mem.rd_data = store_r[mem.rd_addr];

endmodule

// [tb/qsb_sram_if_properties.sv]
`timescale 1ns/10ps
module qsb_sram_if_properties
  import qsb_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // controller side
  input wire logic i_read_port_select_n,
  input wire logic i_dll_disable_n,
  // read side
  input wire logic [QSB_WORD_W-1:0] o_rdata_k,
  input wire logic [QSB_WORD_W-1:0] o_rdata_kb,
  input wire logic o_rdata_oe,
  input wire logic o_legacy_latency_mode
);
  logic rd_take;
  logic [3:0] rd_hist_r;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // a read starts unless one started on the edge before
  assign rd_take = !i_read_port_select_n && !rd_hist_r[0];
  // history of read starts, newest in bit 0
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_hist_r <= 4'h0;
    end else begin
      rd_hist_r <= {rd_hist_r[2:0], rd_take};
    end
  end
  a_oe_two_cycle: assert property (!o_legacy_latency_mode |->
    o_rdata_oe == (rd_hist_r[2] || rd_hist_r[3])) else $error("two-cycle read window wrong");
  a_oe_legacy: assert property (o_legacy_latency_mode |->
    o_rdata_oe == (rd_hist_r[1] || rd_hist_r[2])) else $error("legacy read window wrong");
  a_mode_legacy_on: assert property (!i_dll_disable_n [*7] |-> o_legacy_latency_mode)
    else $error("legacy mode not entered");
  a_mode_legacy_off: assert property (i_dll_disable_n [*7] |-> !o_legacy_latency_mode)
    else $error("legacy mode not left");
  a_mode_steady: assert property ($stable(i_dll_disable_n) [*7] |->
    $stable(o_legacy_latency_mode)) else $error("mode moved without strap change");
  a_idle_data_hold: assert property (!o_rdata_oe |->
    $stable(o_rdata_k) && $stable(o_rdata_kb)) else $error("read data moved while floating");
  a_burst_two_halves: assert property ($rose(o_rdata_oe) |=> o_rdata_oe)
    else $error("burst shorter than two cycles");
  // output only after a read start
  a_rise_needs_read: assert property ($rose(o_rdata_oe) |->
    (o_legacy_latency_mode ? $past(rd_take, 2) : $past(rd_take, 3)))
    else $error("read output without a read start");
  a_deselect_float: assert property ((rd_hist_r == 4'h0) ##1 (rd_hist_r == 4'h0) |->
    !o_rdata_oe) else $error("outputs driven with no read pending");
endmodule

// [tb/qsb_ctrl_model.sv]
`timescale 1ns/10ps
module qsb_ctrl_model
  import qsb_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // towards the memory
  output logic o_read_port_select_n,
  output logic o_write_port_select_n,
  output logic [QSB_AW-1:0] o_addr,
  output logic [QSB_WORD_W-1:0] o_wdata_k,
  output logic [QSB_WORD_W-1:0] o_wdata_kb,
  output logic [1:0] o_byte_write_select_k_n,
  output logic [1:0] o_byte_write_select_kb_n
);
  integer seed = 12282;
  logic [QSB_BURST_W-1:0] p1_d, p2_d;
  logic [QSB_LANES-1:0] p1_l, p2_l;
  logic p1_v = 1'b0;
  logic p2_v = 1'b0;
  // both ports deselected at time zero
  initial begin
    o_read_port_select_n = 1'b1;
    o_write_port_select_n = 1'b1;
    o_addr = '0;
    {o_wdata_k, o_wdata_kb} = '0;
    {o_byte_write_select_k_n, o_byte_write_select_kb_n} = 4'hF;
  end
  task automatic issue(input logic rd, input logic wr, input logic [QSB_AW-1:0] a,
      input logic [QSB_BURST_W-1:0] d, input logic [QSB_LANES-1:0] ln, input logic dv);
    @(posedge i_ref_clk);
    #1;
    o_read_port_select_n = !rd;
    o_write_port_select_n = !wr;
    o_addr = (rd || wr) ? a : QSB_AW'($random(seed));
    if (p1_v) begin
      {o_wdata_kb, o_wdata_k} = p1_d[35:0];
      {o_byte_write_select_kb_n, o_byte_write_select_k_n} = p1_l[3:0];
    end else if (p2_v) begin
      {o_wdata_kb, o_wdata_k} = p2_d[71:36];
      {o_byte_write_select_kb_n, o_byte_write_select_k_n} = p2_l[7:4];
    end else begin
      {o_wdata_kb, o_wdata_k} = QSB_HALF_W'({$random(seed), $random(seed)});
      {o_byte_write_select_kb_n, o_byte_write_select_k_n} = 4'($random(seed));
    end
    {p2_v, p2_d, p2_l} = {p1_v, p1_d, p1_l};
    {p1_v, p1_d, p1_l} = {dv, d, ln};
  endtask
endmodule

// [tb/qsb_sram_if_tb.sv]
`timescale 1ns/10ps
module qsb_sram_if_tb;
  import qsb_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic dll_n = 1'b1;
  logic rps_n, wps_n, oe, legacy;
  logic [QSB_AW-1:0] addr;
  logic [QSB_WORD_W-1:0] wd_k, wd_kb, rd_k, rd_kb;
  logic [1:0] bw_k_n, bw_kb_n;
  logic [QSB_BURST_W-1:0] mem [logic [QSB_AW-1:0]];
  logic [QSB_BURST_W-1:0] exp_q [$];
  logic [QSB_AW-1:0] tbl [4] = '{20'h00000, 20'hFFFFF, 20'h5A5A5, 20'h0F0F0};
  logic [QSB_LANES-1:0] lanes [3] = '{8'h3C, 8'h96, 8'hFF};
  logic last_rd = 1'b0;
  logic last_wr = 1'b0;
  logic half = 1'b0;
  logic [QSB_HALF_W-1:0] lo;
  logic [31:0] rv;
  integer seed = 12282;
  int num_errors = 0;
  int n_tests = 0;
  always #20 i_ref_clk = !i_ref_clk;
  qsb_sram_if qsb_sram_if_inst (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_read_port_select_n(rps_n), .i_write_port_select_n(wps_n), .i_addr(addr),
    .i_wdata_k(wd_k), .i_wdata_kb(wd_kb), .i_byte_write_select_k_n(bw_k_n),
    .i_byte_write_select_kb_n(bw_kb_n), .i_dll_disable_n(dll_n), .o_rdata_k(rd_k),
    .o_rdata_kb(rd_kb), .o_rdata_oe(oe), .o_legacy_latency_mode(legacy));
  qsb_ctrl_model qsb_ctrl_model_inst (.i_ref_clk(i_ref_clk), .o_read_port_select_n(rps_n),
    .o_write_port_select_n(wps_n), .o_addr(addr), .o_wdata_k(wd_k), .o_wdata_kb(wd_kb),
    .o_byte_write_select_k_n(bw_k_n), .o_byte_write_select_kb_n(bw_kb_n));
  // compares and counts
  task automatic check(input logic [QSB_BURST_W-1:0] seen, input logic [QSB_BURST_W-1:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one cycle of traffic; notes expected bursts and updates the shadow array
  task automatic op(input logic rd, input logic wr, input int ai, input logic [7:0] ln);
    logic [95:0] r;
    logic tr, tw;
    logic [QSB_AW-1:0] a;
    r = {$random(seed), $random(seed), $random(seed)};
    a = tbl[ai];
    tr = rd && !last_rd;
    tw = wr && !last_wr && !tr;
    if (tr) exp_q.push_back(mem[a]);
    for (int i = 0; i < QSB_LANES; i++) begin
      if (tw && !ln[i]) mem[a][i*QSB_LANE_W +: QSB_LANE_W] = r[i*QSB_LANE_W +: QSB_LANE_W];
    end
    last_rd = tr;
    last_wr = tw;
    qsb_ctrl_model_inst.issue(rd, wr, a, r[QSB_BURST_W-1:0], ln, tw);
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 0, 8'h00);
  endtask
  // gathers each burst over two edges and compares with the oldest note
  always @(posedge i_ref_clk) begin
    if (half) begin
      half = 1'b0;
      if (exp_q.size() == 0) begin
        check(72'h0, 72'h1);
      end else begin
        check({rd_kb, rd_k, lo}, exp_q.pop_front());
      end
    end else if (oe === 1'b1) begin
      lo = {rd_kb, rd_k};
      half = 1'b1;
    end
  end
  // cuts a hang; the tests need well under 20 us
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge i_ref_clk);
    #1;
    i_arst_n = 1'b1;
    // full writes to every table address, then spaced reads
    for (int i = 0; i < 8; i++) begin
      op(1'b0, 1'b0, i % 4, 8'h00);
      op(1'b0, i < 4, i % 4, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 1'b0, i, 8'h00);
      idle(1);
    end
    // partial and empty lane writes, read after each
    foreach (lanes[i]) begin
      op(1'b0, 1'b1, 0, lanes[i]);
      idle(1);
      op(1'b1, 1'b0, 0, 8'h00);
      idle(1);
    end
    // second request of a pair is dropped
    op(1'b1, 1'b0, 1, 8'h00);
    op(1'b1, 1'b0, 2, 8'h00);
    op(1'b0, 1'b1, 2, 8'h00);
    op(1'b0, 1'b1, 3, 8'h00);
    idle(1);
    op(1'b1, 1'b0, 3, 8'h00);
    idle(1);
    op(1'b1, 1'b0, 2, 8'h00);
    idle(2);
    for (int i = 0; i < 6; i++) op(1'b1, 1'b1, i % 4, 8'h00);
    // random mix with noise between bursts
    for (int i = 0; i < 60; i++) begin
      rv = $random(seed);
      op(rv[0], rv[1], int'(rv[3:2]), rv[11:4]);
    end
    idle(8);
    dll_n = 1'b0;
    idle(8);
    check({71'h0, legacy}, 72'h1);
    // legacy forwarding of a write into the next read
    op(1'b0, 1'b1, 1, 8'h0F);
    op(1'b1, 1'b0, 1, 8'h00);
    op(1'b0, 1'b1, 0, 8'h00);
    op(1'b1, 1'b0, 0, 8'h00);
    op(1'b1, 1'b0, 2, 8'h00);
    idle(8);
    dll_n = 1'b1;
    idle(8);
    check({71'h0, legacy}, 72'h0);
    check(72'(exp_q.size()), 72'h0);
    tally_and_finish();
  end
endmodule
bind qsb_sram_if qsb_sram_if_properties qsb_sram_if_properties_inst (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_read_port_select_n(i_read_port_select_n),
  .i_dll_disable_n(i_dll_disable_n), .o_rdata_k(o_rdata_k), .o_rdata_kb(o_rdata_kb),
  .o_rdata_oe(o_rdata_oe), .o_legacy_latency_mode(o_legacy_latency_mode));
